// >>> core/adc_port_pkg.sv
// Overview of operation
// RULE1: Falling chip select starts a new exchange
// RULE2: Three-wire: first clock pulse enables output
// RULE3: Host raises chip select; port then resets
// RULE4: Four-wire: configuration bits sampled on rise
// RULE5: Output changes on rise; host samples next
// RULE6: Leading zeros ignored; first one starts
// RULE7: Four bits after start, then input ignored
// RULE8: Address bits select single or differential pair
// RULE9: Dummy bits ignored; give acquisition window
// RULE10: Two null bits, then eight result bits
// RULE11: MSB first, then zeros while clocked
// RULE12: Three-wire: no word, fixed differential pair
// RULE13: Result is straight unipolar binary code
// RULE14: Shared wire driven low on fifth fall
// RULE15: Host releases shared wire before device drives
// RULE16: Two-channel part idles converter between conversions
// RULE17: Host clocks at top rate for speed; model host runs 12.5 MHz, under it
// RULE18: Fall after second dummy enters hold, converts
// RULE19: Conversion lasts eight and half clocks
// RULE20: Power only while chip select low
// RULE21: Output high impedance outside enabled exchange
package adc_port_pkg;

    // ==========================================================
    // Word and timing figures
    // ==========================================================
    localparam int RESULT_W = 8;
    localparam int CFG_BITS = 4;
    localparam int CNT_W = 3;
    localparam int CONV_HALF_CLKS = 17;
    localparam int ACQ_HALF_CLKS = 5;
    localparam int CONV_CNT_W = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int MAX_SHIFT_CLK_HZ = 14_400_000;

    localparam logic [CNT_W-1:0] CFG_MUX_LAST = 3'h1;
    localparam logic [CNT_W-1:0] CFG_LAST = 3'h3;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = 5'h10;

    // ==========================================================
    // Multiplexer address codes {single_ended_select, polarity}
    // ==========================================================
    localparam logic [1:0] MUX_SGL_A = 2'h2;
    localparam logic [1:0] MUX_SGL_B = 2'h3;
    localparam logic [1:0] MUX_DIFF_AB = 2'h0;
    localparam logic [1:0] MUX_DIFF_BA = 2'h1;
    localparam logic [1:0] MUX_RESET = 2'h0;

    // ==========================================================
    // Port sequencer states
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HUNT = 3'b001,
        ST_CONFIG = 3'b010,
        ST_LAUNCH = 3'b011,
        ST_SHIFT = 3'b100
    } port_state_t;

endpackage : adc_port_pkg

// >>> core/pin_edges.sv
module pin_edges
    import adc_port_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic shift_clk, // Shift clock pin level
    input wire logic chip_sel_n, // Chip select pin, active low
    output logic clk_rise, // Shift clock rose, one cycle
    output logic clk_fall, // Shift clock fell, one cycle
    output logic sel_fall // Chip select fell, one cycle
);

    // ==========================================================
    // Edge detection
    // ==========================================================
    logic shift_clk_ff;
    logic chip_sel_n_ff;

    // Previous pin levels; chip select resets high, shift clock low, so no false edge at start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_clk_ff <= 1'b0;
            chip_sel_n_ff <= 1'b1;
        end else begin
            shift_clk_ff <= shift_clk;
            chip_sel_n_ff <= chip_sel_n;
        end
    end

    // Edge pulses
    assign clk_rise = shift_clk & ~shift_clk_ff;
    assign clk_fall = ~shift_clk & shift_clk_ff;
    assign sel_fall = ~chip_sel_n & chip_sel_n_ff;

endmodule : pin_edges

// >>> core/result_fifo.sv
module result_fifo
    import adc_port_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic in_valid, // Write word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word written
    output logic out_valid, // Word available
    input wire logic out_ready, // Reader takes word
    output logic [WIDTH-1:0] out_data // Oldest word
);

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic full_ff;
    logic empty_ff;
    logic do_wr;
    logic do_rd;
    logic [AW:0] nxt_count;

    assign do_wr = in_valid & ~full_ff;
    assign do_rd = out_ready & ~empty_ff;
    assign in_ready = ~full_ff;
    assign out_valid = ~empty_ff;
    assign out_data = mem[rd_ptr_ff];

    // Occupancy after this cycle
    always_comb begin
        nxt_count = count_ff;
        if (do_wr && !do_rd) begin
            nxt_count = count_ff + 1'b1;
        end else if (do_rd && !do_wr) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // Array write; no reset needed on data
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap naturally for power-of-two depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            full_ff <= (nxt_count == FULL_CNT);
            empty_ff <= (nxt_count == '0);
        end
    end

endmodule : result_fifo

// >>> core/serial_adc_port.sv
module serial_adc_port
    import adc_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic four_wire, // 1: two-channel variant
    input wire logic chip_sel_n, // Chip select pin, active low
    input wire logic shift_clk, // Shift clock pin
    input wire logic data_in, // Serial data input pin
    output logic data_out, // Serial data output pin
    output logic data_out_oe, // High while driving data_out
    input wire logic code_valid, // Quantizer result offered
    output logic code_ready, // Result queue has room
    input wire logic [RESULT_W-1:0] code_data, // Quantizer result
    output logic single_ended_select, // 1: channel versus ground
    output logic polarity_select, // Channel or sign select
    output logic plus_on_input_b, // Plus side is input b
    output logic minus_on_ground, // Minus side is ground
    output logic sampling, // Acquisition window open
    output logic converting, // Hold and conversion active
    output logic power_on, // Converter powered
    output logic underrun // Launch found queue empty
);

    // ==========================================================
    // Pin edges and result queue
    // ==========================================================
    // Pins arrive as levels on the system clock
    // Shift clock edges and the chip select fall become one-cycle pulses
    // Limit: two system clocks per shift half period
    // Codes wait in the queue until launch

    logic clk_rise;
    logic clk_fall;
    logic sel_fall;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_ready;
    logic [RESULT_W-1:0] fifo_data;

    pin_edges u_edges (
        .clk(clk),
        .rst_n(rst_n),
        .shift_clk(shift_clk),
        .chip_sel_n(chip_sel_n),
        .clk_rise(clk_rise),
        .clk_fall(clk_fall),
        .sel_fall(sel_fall)
    );

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(code_valid),
        .in_ready(fifo_ready),
        .in_data(code_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ==========================================================
    // Sequencer state
    // ==========================================================
    // Idle, hunt for start, take word, wait, shift
    // Three-wire exchanges skip hunt and word
    // Launch state waits for the ending fall
    // Chip select high returns to idle from anywhere
    // Trade-off: no timeout; host must end frames

    port_state_t state_ff;
    port_state_t nxt_state;
    logic [CNT_W-1:0] cfg_cnt_ff;
    logic [1:0] mux_sr_ff;
    logic [RESULT_W-1:0] res_sr_ff;
    logic null_done_ff;
    logic [CONV_CNT_W-1:0] conv_cnt_ff;
    logic launch;
    logic [1:0] route; // Pair routing of the stored address

    // Decode a mux address into the pair routing
    function automatic logic [1:0] route_of(input logic [1:0] addr);
        logic [1:0] r;
        r = 2'b00;
        case (addr)
            MUX_SGL_A: r = 2'b01; // RULE8
            MUX_SGL_B: r = 2'b11; // RULE8
            MUX_DIFF_AB: r = 2'b00; // RULE8
            MUX_DIFF_BA: r = 2'b10; // RULE8
            default: r = 2'b00;
        endcase
        return r;
    endfunction : route_of

    // Conversion launch is the fall that ends the setup phase
    assign launch = clk_fall && !chip_sel_n &&
                    (state_ff == ST_LAUNCH); // RULE18 RULE14 RULE2
    assign fifo_pop = launch;

    // Next state; chip select high always wins
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (sel_fall) begin // RULE1
                    // RULE12
                    nxt_state = four_wire ? ST_HUNT : ST_LAUNCH;
                end
            end
            ST_HUNT: begin
                if (clk_rise && data_in) begin // RULE6
                    nxt_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (clk_rise && cfg_cnt_ff == CFG_LAST) begin // RULE7
                    nxt_state = ST_LAUNCH;
                end
            end
            ST_LAUNCH: begin
                if (launch) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: nxt_state = ST_SHIFT; // RULE7
            default: nxt_state = ST_IDLE;
        endcase
        if (chip_sel_n) begin
            nxt_state = ST_IDLE; // RULE3
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Configuration word capture
    // ==========================================================
    // Word bits land on seen shift clock rises
    // Only the two address bits are kept
    // Address survives the frame for the routing ports
    // Hazard: stale address shows until the next word

    // Dummy bits are counted but their values are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_cnt_ff <= '0;
            mux_sr_ff <= MUX_RESET;
        end else if (state_ff != ST_CONFIG) begin
            cfg_cnt_ff <= '0;
        end else if (clk_rise) begin // RULE4
            cfg_cnt_ff <= cfg_cnt_ff + 1'b1; // RULE9
            if (cfg_cnt_ff <= CFG_MUX_LAST) begin
                mux_sr_ff <= {mux_sr_ff[0], data_in}; // RULE8
            end
        end
    end

    // Pair routing decoded from the stored address
    assign route = route_of(mux_sr_ff);

    // Routing outputs; fixed differential pair on three wires
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_ended_select <= 1'b0;
            polarity_select <= 1'b0;
            plus_on_input_b <= 1'b0;
            minus_on_ground <= 1'b0;
        end else if (!four_wire) begin
            single_ended_select <= 1'b0; // RULE12
            polarity_select <= 1'b0;
            plus_on_input_b <= 1'b0;
            minus_on_ground <= 1'b0;
        end else begin
            single_ended_select <= mux_sr_ff[1];
            polarity_select <= mux_sr_ff[0];
            plus_on_input_b <= route[1];
            minus_on_ground <= route[0];
        end
    end

    // ==========================================================
    // Acquisition, conversion and power
    // ==========================================================
    // Window and hold are exclusive levels
    // Launch fall closes one and opens the other
    // Hold length counts both shift clock edges
    // Abort by chip select clears both at once

    // Window opens with the bit before the first dummy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampling <= 1'b0;
        end else if (chip_sel_n || launch) begin
            sampling <= 1'b0; // RULE18
        end else if (state_ff == ST_CONFIG && clk_rise &&
                     cfg_cnt_ff == CFG_MUX_LAST) begin
            sampling <= 1'b1; // RULE9
        end
    end

    // Conversion spans 17 half clocks from the launch fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converting <= 1'b0;
            conv_cnt_ff <= '0;
        end else if (chip_sel_n) begin
            converting <= 1'b0;
            conv_cnt_ff <= '0;
        end else if (launch) begin
            converting <= 1'b1; // RULE18
            conv_cnt_ff <= '0;
        end else if (converting && (clk_rise || clk_fall)) begin
            conv_cnt_ff <= conv_cnt_ff + 1'b1;
            if (conv_cnt_ff == CONV_LAST) begin
                converting <= 1'b0; // RULE19 RULE16
            end
        end
    end

    // Power simply follows the pin, one clock late
    // Gating of the converter itself is left outside
    // Power follows chip select; idle between exchanges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on <= 1'b0;
        end else begin
            power_on <= ~chip_sel_n; // RULE20
        end
    end

    // ==========================================================
    // Result shifting
    // ==========================================================
    // Word popped at launch, sent after two nulls
    // Shift register zero-fills behind the MSB
    // Empty queue: zero code and a flag held until the next launch
    // Hazard: host must release a shared wire first

    // Result loads at launch; empty queue gives zero and a flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_sr_ff <= '0;
            null_done_ff <= 1'b0;
            underrun <= 1'b0;
        end else if (chip_sel_n) begin
            res_sr_ff <= '0;
            null_done_ff <= 1'b0;
        end else if (launch) begin
            // RULE13
            res_sr_ff <= fifo_valid ? fifo_data : '0;
            null_done_ff <= 1'b0;
            underrun <= ~fifo_valid;
        end else if (state_ff == ST_SHIFT && clk_rise) begin
            null_done_ff <= 1'b1; // RULE10
            if (null_done_ff) begin
                // Zero fill gives endless zeros after the LSB
                res_sr_ff <= {res_sr_ff[RESULT_W-2:0], 1'b0}; // RULE11
            end
        end
    end

    // Enable rises with the first null, on a fall
    // Later bits move one clock after each seen rise
    // Enable drops one clock after chip select rises

    // Pin drive: first null on launch fall, bits on rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 1'b0;
            data_out_oe <= 1'b0;
        end else if (chip_sel_n) begin
            data_out <= 1'b0;
            data_out_oe <= 1'b0; // RULE21 RULE3
        end else if (launch) begin
            data_out <= 1'b0; // RULE14 RULE10
            data_out_oe <= 1'b1; // RULE2
        end else if (state_ff == ST_SHIFT && clk_rise) begin
            // RULE5
            data_out <= null_done_ff ? res_sr_ff[RESULT_W-1] : 1'b0;
        end
    end

    // One clock late; the queue itself never overflows
    // Back-pressure toward the quantizer, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ready <= 1'b0;
        end else begin
            code_ready <= fifo_ready;
        end
    end

endmodule : serial_adc_port

// >>> sim/host_ctrl_model.sv
module host_ctrl_model #(
    parameter int HALF = 4 // 12.5 MHz shift clock, under top rate
) (
    input wire logic clk, // System clock
    output logic chip_sel_n, // Chip select, active low
    output logic shift_clk, // Shift clock
    output logic data_in, // Resolved data wire
    input wire logic data_out, // Device data
    input wire logic data_out_oe // Device drives wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_en = 1'b1;
    logic host_bit = 1'b0;
    logic filler = 1'b0;
    initial begin
        chip_sel_n = 1'b1;
        shift_clk = 1'b0;
    end

    // ========
    // Wire
    // ========
    // Released wire toggles so a stale level never reads as valid
    always @(posedge clk) filler <= ~filler;
    assign data_in = host_en ? host_bit : (data_out_oe ? data_out : filler);

    // One pulse; the device bit is taken just before the rise
    task automatic pulse(input logic b, output logic got);
        host_bit = b;
        repeat (HALF) @(negedge clk);
        got = data_out_oe ? data_out : ~data_out;
        shift_clk = 1'b1;
        repeat (HALF) @(negedge clk);
        shift_clk = 1'b0;
    endtask : pulse

    // Four-wire: lead zeros, start, config word; three-wire: one pulse; then eleven reads
    task automatic exchange(input logic fw, input logic [3:0] cfg,
            input int lead, input logic shared, input logic abort,
            output logic [10:0] rx);
        logic g;
        chip_sel_n = 1'b0;
        host_en = 1'b1;
        if (fw) begin
            for (int i = 0; i < lead; i++) pulse(1'b0, g);
            pulse(1'b1, g);
            for (int i = 3; i >= 0; i--) begin
                if (abort && i < 2) return;
                pulse(cfg[i], g);
            end
        end else begin
            pulse(1'($urandom), g);
        end
        host_en = !shared;
        for (int i = 10; i >= 0; i--) pulse(1'($urandom), rx[i]);
    endtask : exchange

    task automatic end_frame();
        repeat (HALF) @(negedge clk);
        chip_sel_n = 1'b1;
        host_en = 1'b1;
        repeat (2 * HALF) @(negedge clk);
    endtask : end_frame
endmodule : host_ctrl_model

// >>> sim/serial_adc_port_monitor.sv
module serial_adc_port_monitor (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic chip_sel_n, // Chip select pin
    input wire logic shift_clk, // Shift clock pin
    input wire logic data_out, // Serial output
    input wire logic data_out_oe, // Output enable
    input wire logic single_ended_select, // Mux mode
    input wire logic polarity_select, // Mux polarity
    input wire logic plus_on_input_b, // Plus routing
    input wire logic minus_on_ground, // Minus routing
    input wire logic sampling, // Acquisition window
    input wire logic converting, // Hold and convert
    input wire logic power_on // Converter powered
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic sclk_ff;
    logic [4:0] edges_ff;

    // ========
    // Helpers
    // ========
    // Pin edges counted while converting, not the design's own view
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_ff <= 1'b0;
            edges_ff <= 5'h00;
        end else begin
            sclk_ff <= shift_clk;
            if (!converting) edges_ff <= 5'h00;
            else if (shift_clk != sclk_ff) edges_ff <= edges_ff + 5'h01;
        end
    end

    sequence cs_idle;
        chip_sel_n [*3];
    endsequence
    sequence launch;
        !shift_clk && !chip_sel_n ##1 $rose(data_out_oe);
    endsequence
    sequence sel_steady;
        ($stable(single_ended_select) && $stable(polarity_select)) [*3];
    endsequence

    // ========
    // Checks
    // ========
    AST_OE_OFF: assert property (
        cs_idle |-> !data_out_oe) else $error("output driven while idle");
    AST_POWER: assert property (
        power_on == !$past(chip_sel_n)) else $error("power not following cs");
    AST_LAUNCH_ON_FALL: assert property (
        $rose(data_out_oe) |-> !$past(shift_clk) && !$past(chip_sel_n))
        else $error("output enabled off a falling edge");
    AST_FIRST_NULL: assert property (
        launch |-> !data_out && converting && !sampling)
        else $error("launch state wrong");
    AST_CONV_LEN: assert property (
        $fell(converting) && !chip_sel_n |-> edges_ff == 5'h11)
        else $error("conversion length wrong");
    AST_SHIFT_ON_RISE: assert property (
        $changed(data_out) && data_out_oe && $past(data_out_oe)
        |-> $past(shift_clk)) else $error("output moved off a rise");
    AST_ROUTE: assert property (
        sel_steady |-> minus_on_ground == single_ended_select
        && plus_on_input_b == polarity_select) else $error("routing wrong");
    AST_PHASE_EXCL: assert property (
        !(sampling && converting)) else $error("sample and hold overlap");
    AST_WINDOW_END: assert property (
        $fell(sampling) && !chip_sel_n |-> converting)
        else $error("window closed without hold");
endmodule : serial_adc_port_monitor

bind serial_adc_port serial_adc_port_monitor u_monitor (
    .clk(clk),
    .rst_n(rst_n),
    .chip_sel_n(chip_sel_n),
    .shift_clk(shift_clk),
    .data_out(data_out),
    .data_out_oe(data_out_oe),
    .single_ended_select(single_ended_select),
    .polarity_select(polarity_select),
    .plus_on_input_b(plus_on_input_b),
    .minus_on_ground(minus_on_ground),
    .sampling(sampling),
    .converting(converting),
    .power_on(power_on)
);

// >>> sim/serial_adc_port_tb_top.sv
module serial_adc_port_tb_top;
    import adc_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic four_wire = 1'b1;
    logic code_valid = 1'b0;
    logic [RESULT_W-1:0] code_data = 8'h00;
    logic chip_sel_n, shift_clk, data_in, data_out, data_out_oe;
    logic code_ready, single_ended_select, polarity_select;
    logic plus_on_input_b, minus_on_ground, sampling, converting;
    logic power_on, underrun;
    logic [10:0] rx;
    logic [7:0] q[$];
    int failures = 0;
    int tests_run = 0;

    serial_adc_port #(.DEPTH(FIFO_DEPTH)) uut (
        .clk(clk), .rst_n(rst_n), .four_wire(four_wire),
        .chip_sel_n(chip_sel_n), .shift_clk(shift_clk),
        .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe),
        .code_valid(code_valid), .code_ready(code_ready),
        .code_data(code_data), .single_ended_select(single_ended_select),
        .polarity_select(polarity_select),
        .plus_on_input_b(plus_on_input_b),
        .minus_on_ground(minus_on_ground), .sampling(sampling),
        .converting(converting), .power_on(power_on), .underrun(underrun)
    );
    host_ctrl_model host (
        .clk(clk), .chip_sel_n(chip_sel_n), .shift_clk(shift_clk),
        .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe)
    );

    // ========
    // Tasks
    // ========
    task automatic check(input string what, input logic [10:0] exp,
            input logic [10:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // One offer; the model queue only grows while below depth
    task automatic push(input logic [7:0] v);
        code_valid = 1'b1;
        code_data = v;
        @(negedge clk);
        if (q.size() < FIFO_DEPTH) q.push_back(v);
        code_valid = 1'b0;
        repeat (2) @(negedge clk);
        check("code_ready", 11'(q.size() < FIFO_DEPTH), 11'(code_ready));
    endtask : push

    // Full exchange; empty queue means code zero and underrun
    task automatic run(input logic fw, input logic [1:0] mux,
            input logic sh);
        logic [7:0] exp;
        logic under;
        four_wire = fw;
        under = (q.size() == 0);
        exp = under ? 8'h00 : q.pop_front();
        host.exchange(fw, {mux, 2'($urandom)}, int'($urandom_range(3)),
            sh, 1'b0, rx);
        check("result", {2'b00, exp, 1'b0}, rx);
        check("status", 11'({fw & mux[1], fw & mux[0], fw & mux[0],
            fw & mux[1], 1'b1, under}), 11'({single_ended_select,
            polarity_select, plus_on_input_b, minus_on_ground, power_on,
            underrun}));
        host.end_frame();
        check("idle", 11'h000, 11'({data_out_oe, power_on}));
    endtask : run

    // ========
    // Clock and watchdog
    // ========
    initial begin
        forever #5 clk = ~clk;
    end
    // Whole run is under 3000 cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end

    // ========
    // Tests
    // ========
    initial begin
        void'($urandom(47311));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("reset", 11'h001,
            11'({data_out_oe, power_on, code_ready}));
        push(8'h00);
        push(8'h01);
        push(8'hff);
        // Last offer meets a full queue and must be refused
        for (int i = 0; i < 14; i++) push(8'($urandom));
        for (int i = 0; i < 16; i++) run(i < 12, 2'(i), i[2]);
        run(1'b1, MUX_SGL_A, 1'b1);
        push(8'h5a);
        // Abort inside the window; queued word must survive
        host.exchange(1'b1, 4'hc, 0, 1'b0, 1'b1, rx);
        host.end_frame();
        check("abort", 11'h000, 11'(data_out_oe));
        run(1'b1, MUX_SGL_B, 1'b0);
        conclude();
    end
endmodule : serial_adc_port_tb_top
